// >>> src/motor_control_option_registers.v
// Purpose: option register bank steering start-up, protection, gate and tach settings
// Assumes: host register port is a decoded single-cycle read/write strobe
// Notes: read data registered one cycle after read strobe
`timescale 1ns/1ps
`default_nettype none
`include "motor_option_defs.vh"
module motor_control_option_registers
(
  // clock and reset
  input wire clock,
  input wire rstn,
  // register port
  input wire [7:0] reg_addr,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  // decoded settings
  output reg handover_valid,
  output reg [17:0] handover_speed_mhz,
  output reg [2:0] rotor_align_duration,
  output reg no_motor_fault_enable,
  output reg lock_enable_torque_const,
  output reg lock_enable_abnormal_speed,
  output reg lock_enable_current,
  output reg inductive_surge_guard_enable,
  output reg mechanical_surge_guard_enable,
  output reg mechanical_surge_guard_target,
  output reg sense_release_style,
  output reg accel_limit_enable,
  output reg [11:0] accel_current_limit_ma,
  output reg [11:0] lock_current_threshold_ma,
  output reg lock_enable_closed_stuck,
  output reg [2:0] closed_loop_ramp,
  output reg [9:0] dead_time_ns,
  output reg dead_time_below_min_12v,
  output reg dead_time_below_min_24v,
  output reg sense_enable,
  output reg [11:0] sense_current_threshold_ma,
  output reg lock_enable_open_stuck,
  output reg buck_voltage_choice,
  output reg [1:0] sense_pulse_rate,
  output reg [1:0] tach_open_loop_choice,
  output reg tach_choice_reserved,
  output reg [1:0] tach_pulse_ratio,
  output reg torque_const_high_double,
  output reg torque_const_low_half,
  output reg speed_input_kind,
  output reg closed_loop_inhibit
);

  reg [7:0] handover_reg;
  reg [7:0] lock_reg;
  reg [7:0] limit_reg;
  reg [7:0] gate_reg;
  reg [7:0] sense_reg;
  reg [7:0] tach_reg;
  reg [7:0] rdata_next;

  function [7:0] write_mux;
    input [7:0] old_value;
    input [7:0] new_value;
    input [7:0] mask;
    input hit;
    begin
      write_mux = hit ? (new_value & mask) : old_value;
    end
  endfunction

  // one write strobe steered to one register address
  function write_hit;
    input strobe;
    input [7:0] addr;
    input [7:0] target;
    begin
      write_hit = strobe && (addr == target);
    end
  endfunction

  // two speed ranges, the upper one counted from one step
  // the top code gives 204.8 Hz, so the result needs 18 bits of mHz
  function [17:0] handover_mhz;
    input [7:0] value;
    begin
      if (value[`BIT_SPEED_RANGE])
        handover_mhz = ({14'h0000, value[`FLD_SPEED_STEP]} + 18'h0_0001) * `SPEED_HIGH_STEP_MHZ;
      else
        handover_mhz = {14'h0000, value[`FLD_SPEED_STEP]} * `SPEED_LOW_STEP_MHZ;
    end
  endfunction

  // n steps, or n+1 steps for fields that count from one step up
  // callers keep the product inside 12 bits
  function [11:0] current_ma;
    input [3:0] code;
    input add_one;
    input [11:0] step;
    begin
      current_ma = ({8'h00, code} + {11'h000, add_one}) * step;
    end
  endfunction

  // dead time counts from one step, so code zero is never zero time
  function [9:0] dead_ns;
    input [3:0] code;
    begin
      dead_ns = ({6'h00, code} + 10'h001) * `DEAD_STEP_NS;
    end
  endfunction

  always @(posedge clock)
  begin
    if (!rstn)
    begin
      handover_reg <= `RESET_VALUE;
      lock_reg <= `RESET_VALUE;
      limit_reg <= `RESET_VALUE;
      gate_reg <= `RESET_VALUE;
      sense_reg <= `RESET_VALUE;
      tach_reg <= `RESET_VALUE;
    end
    else
    begin
      // unused bit 0 of current limit is dropped on write
      handover_reg <= write_mux(handover_reg, reg_wdata, `MASK_ALL,
        write_hit(reg_write, reg_addr, `ADDR_LOOP_HANDOVER));
      lock_reg <= write_mux(lock_reg, reg_wdata, `MASK_ALL,
        write_hit(reg_write, reg_addr, `ADDR_LOCK_SURGE));
      limit_reg <= write_mux(limit_reg, reg_wdata, `MASK_CURRENT_LIMIT,
        write_hit(reg_write, reg_addr, `ADDR_CURRENT_LIMIT));
      gate_reg <= write_mux(gate_reg, reg_wdata, `MASK_ALL,
        write_hit(reg_write, reg_addr, `ADDR_CLOSED_LOOP_GATE));
      sense_reg <= write_mux(sense_reg, reg_wdata, `MASK_ALL,
        write_hit(reg_write, reg_addr, `ADDR_INDUCTIVE_SENSE));
      tach_reg <= write_mux(tach_reg, reg_wdata, `MASK_ALL,
        write_hit(reg_write, reg_addr, `ADDR_TACH_SPEED));
    end
  end

  // readback, unmapped addresses read zero
  always @*
  begin
    case (reg_addr)
      `ADDR_LOOP_HANDOVER: rdata_next = handover_reg;
      `ADDR_LOCK_SURGE: rdata_next = lock_reg;
      `ADDR_CURRENT_LIMIT: rdata_next = limit_reg;
      `ADDR_CLOSED_LOOP_GATE: rdata_next = gate_reg;
      `ADDR_INDUCTIVE_SENSE: rdata_next = sense_reg;
      `ADDR_TACH_SPEED: rdata_next = tach_reg;
      default: rdata_next = `RESET_VALUE;
    endcase
  end

  always @(posedge clock)
  begin
    if (!rstn)
    begin
      reg_rdata <= `RESET_VALUE;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_read;
      if (reg_read)
        reg_rdata <= rdata_next;
    end
  end

  // handover speed and align time, code zero marked invalid
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      handover_valid <= 1'b0;
      handover_speed_mhz <= 18'h0_0000;
      rotor_align_duration <= 3'h0;
    end
    else
    begin
      handover_valid <= handover_reg[`FLD_SPEED_CODE] != 5'h00;
      handover_speed_mhz <= handover_mhz(handover_reg);
      rotor_align_duration <= handover_reg[`FLD_ALIGN_TIME];
    end
  end

  // lock detection and surge guard enables
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      no_motor_fault_enable <= 1'b0;
      lock_enable_torque_const <= 1'b0;
      lock_enable_abnormal_speed <= 1'b0;
      lock_enable_current <= 1'b0;
      inductive_surge_guard_enable <= 1'b0;
      mechanical_surge_guard_enable <= 1'b0;
      mechanical_surge_guard_target <= 1'b0;
      sense_release_style <= 1'b0;
    end
    else
    begin
      no_motor_fault_enable <= lock_reg[`BIT_NO_MOTOR];
      lock_enable_torque_const <= lock_reg[`BIT_TORQUE_CONST];
      lock_enable_abnormal_speed <= lock_reg[`BIT_ABNORMAL_SPEED];
      lock_enable_current <= lock_reg[`BIT_LOCK_CURRENT];
      inductive_surge_guard_enable <= lock_reg[`BIT_INDUCTIVE_GUARD];
      mechanical_surge_guard_enable <= lock_reg[`BIT_MECH_GUARD];
      mechanical_surge_guard_target <= lock_reg[`BIT_MECH_TARGET];
      sense_release_style <= lock_reg[`BIT_RELEASE_STYLE];
    end
  end

  // acceleration and lock current limits
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      accel_limit_enable <= 1'b0;
      accel_current_limit_ma <= 12'h000;
      lock_current_threshold_ma <= 12'h000;
    end
    else
    begin
      accel_limit_enable <= limit_reg[`FLD_ACCEL_LIMIT] != 4'h0;
      // code zero yields zero here, read together with the enable flag
      accel_current_limit_ma <= current_ma(limit_reg[`FLD_ACCEL_LIMIT], 1'b0, `ACCEL_STEP_MA);
      lock_current_threshold_ma <= current_ma({1'b0, limit_reg[`FLD_LOCK_LIMIT]}, 1'b1, `LOCK_STEP_MA);
    end
  end

  // closed-loop stuck detection, ramp and gate dead time
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      lock_enable_closed_stuck <= 1'b0;
      closed_loop_ramp <= 3'h0;
      dead_time_ns <= 10'h000;
      dead_time_below_min_12v <= 1'b0;
      dead_time_below_min_24v <= 1'b0;
    end
    else
    begin
      lock_enable_closed_stuck <= gate_reg[`BIT_CLOSED_STUCK];
      closed_loop_ramp <= gate_reg[`FLD_LOOP_RAMP];
      dead_time_ns <= dead_ns(gate_reg[`FLD_DEAD_TIME]);
      // advisory flags only, a short dead time is still applied as written
      dead_time_below_min_12v <= dead_ns(gate_reg[`FLD_DEAD_TIME]) < `DEAD_MIN_12V_NS;
      dead_time_below_min_24v <= dead_ns(gate_reg[`FLD_DEAD_TIME]) < `DEAD_MIN_24V_NS;
    end
  end

  // inductive sense threshold, open-loop stuck detection and regulator choice
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      sense_enable <= 1'b0;
      sense_current_threshold_ma <= 12'h000;
      lock_enable_open_stuck <= 1'b0;
      buck_voltage_choice <= 1'b0;
      sense_pulse_rate <= 2'h0;
    end
    else
    begin
      sense_enable <= sense_reg[`FLD_SENSE_THRESHOLD] != 4'h0;
      // zero selects align-and-go, so no threshold is reported
      if (sense_reg[`FLD_SENSE_THRESHOLD] == 4'h0)
        sense_current_threshold_ma <= 12'h000;
      else
        sense_current_threshold_ma <= current_ma(sense_reg[`FLD_SENSE_THRESHOLD], 1'b1, `SENSE_STEP_MA);
      lock_enable_open_stuck <= sense_reg[`BIT_OPEN_STUCK];
      buck_voltage_choice <= sense_reg[`BIT_BUCK_CHOICE];
      sense_pulse_rate <= sense_reg[`FLD_SENSE_RATE];
    end
  end

  // tach output, torque-constant bounds, speed input and loop handover
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      tach_open_loop_choice <= 2'h0;
      tach_choice_reserved <= 1'b0;
      tach_pulse_ratio <= 2'h0;
      torque_const_high_double <= 1'b0;
      torque_const_low_half <= 1'b0;
      speed_input_kind <= 1'b0;
      closed_loop_inhibit <= 1'b0;
    end
    else
    begin
      // the reserved loop choice is kept as written and only flagged
      tach_open_loop_choice <= tach_reg[`FLD_TACH_LOOP];
      tach_choice_reserved <= tach_reg[`FLD_TACH_LOOP] == `TACH_RESERVED;
      tach_pulse_ratio <= tach_reg[`FLD_TACH_RATIO];
      torque_const_high_double <= tach_reg[`BIT_TORQUE_HIGH];
      torque_const_low_half <= tach_reg[`BIT_TORQUE_LOW];
      speed_input_kind <= tach_reg[`BIT_SPEED_INPUT];
      closed_loop_inhibit <= tach_reg[`BIT_LOOP_INHIBIT];
    end
  end

endmodule
`default_nettype wire

// >>> src/motor_option_defs.vh
// Purpose: constants for the motor control option register bank
// Assumes: 8-bit registers at byte addresses 0x26..0x2b behind a simple register port
// Notes: values scaled to fixed units (mHz, mA, ns)
// Function
// - handover speed two ranges, zero invalid
// - no-motor and torque-constant detections enable bits
// - abnormal-speed and lock-current detections enable bits
// - inductive surge guard enable bit
// - mechanical surge guard enable and clamp target
// - release style after sensing: brake or hi-z
// - accel current limit n times 0.2 A
// - lock current threshold (n+1) times 0.4 A
// - closed-loop stuck detection enable bit
// - open-loop stuck detection enable bit
// - dead time (n+1) times 40 ns
// - sense threshold zero means align-and-go
// - buck output select 5 V or 3.3 V
// - tach open-loop output choice, 11 reserved
// - tach pulse ratio per electrical cycles
// - torque-constant upper and lower bounds select
// - speed input analog or pwm
// - closed-loop inhibit keeps open loop
`ifndef MOTOR_OPTION_DEFS_VH
`define MOTOR_OPTION_DEFS_VH
`define ADDR_LOOP_HANDOVER 8'h26
`define ADDR_LOCK_SURGE 8'h27
`define ADDR_CURRENT_LIMIT 8'h28
`define ADDR_CLOSED_LOOP_GATE 8'h29
`define ADDR_INDUCTIVE_SENSE 8'h2a
`define ADDR_TACH_SPEED 8'h2b
`define RESET_VALUE 8'h00
`define MASK_ALL 8'hff
`define MASK_CURRENT_LIMIT 8'hfe
`define SPEED_LOW_STEP_MHZ 18'h0_0320
`define SPEED_HIGH_STEP_MHZ 18'h0_3200
`define ACCEL_STEP_MA 12'h00c8
`define LOCK_STEP_MA 12'h0190
`define SENSE_STEP_MA 12'h00c8
`define DEAD_STEP_NS 10'h0028
`define DEAD_MIN_12V_NS 10'h0168
`define DEAD_MIN_24V_NS 10'h0190
`define TACH_RESERVED 2'h3
`define BIT_SPEED_RANGE 7
`define FLD_SPEED_CODE 7:3
`define FLD_SPEED_STEP 6:3
`define FLD_ALIGN_TIME 2:0
`define BIT_NO_MOTOR 7
`define BIT_TORQUE_CONST 6
`define BIT_ABNORMAL_SPEED 5
`define BIT_LOCK_CURRENT 4
`define BIT_INDUCTIVE_GUARD 3
`define BIT_MECH_GUARD 2
`define BIT_MECH_TARGET 1
`define BIT_RELEASE_STYLE 0
`define FLD_ACCEL_LIMIT 7:4
`define FLD_LOCK_LIMIT 3:1
`define BIT_CLOSED_STUCK 7
`define FLD_LOOP_RAMP 6:4
`define FLD_DEAD_TIME 3:0
`define FLD_SENSE_THRESHOLD 7:4
`define BIT_OPEN_STUCK 3
`define BIT_BUCK_CHOICE 2
`define FLD_SENSE_RATE 1:0
`define FLD_TACH_LOOP 7:6
`define FLD_TACH_RATIO 5:4
`define BIT_TORQUE_LOW 3
`define BIT_TORQUE_HIGH 2
`define BIT_SPEED_INPUT 1
`define BIT_LOOP_INHIBIT 0
`endif

// >>> verif/host_model.sv
// Purpose: host side of the register port, one strobe per access
// Assumes: requests change at the falling edge
// Notes: released address and data show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  input wire logic clock,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic [7:0] reg_addr,
  output logic reg_write,
  output logic reg_read,
  output logic [7:0] reg_wdata
);
  initial {reg_addr, reg_write, reg_read, reg_wdata} = 18'h0_0000;
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock);
    {reg_addr, reg_wdata, reg_write} = {a, v, 1'b1};
    @(negedge clock);
    {reg_addr, reg_wdata, reg_write} = {~a, ~v, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic ok);
    @(negedge clock);
    {reg_addr, reg_read} = {a, 1'b1};
    @(negedge clock);
    {v, ok} = {reg_rdata, reg_rvalid};
    {reg_addr, reg_read} = {~a, 1'b0};
  endtask
endmodule
`default_nettype wire

// >>> verif/motor_control_option_registers_tb.sv
// Purpose: directed test of the motor option register bank
// Assumes: host model drives the register port
// Notes: decoded settings are looked at two cycles after reset, or after a later access has let them settle
`timescale 1ns/1ps
`default_nettype none
module motor_control_option_registers_tb;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_write, reg_read, reg_rvalid, handover_valid, tach_choice_reserved;
  wire [17:0] handover_speed_mhz;
  wire [2:0] rotor_align_duration, closed_loop_ramp;
  wire [1:0] sense_pulse_rate, tach_open_loop_choice, tach_pulse_ratio;
  wire no_motor_fault_enable, lock_enable_torque_const, lock_enable_abnormal_speed, lock_enable_current,
    inductive_surge_guard_enable, mechanical_surge_guard_enable, mechanical_surge_guard_target, sense_release_style,
    accel_limit_enable, lock_enable_closed_stuck, dead_time_below_min_12v, dead_time_below_min_24v, sense_enable,
    lock_enable_open_stuck, buck_voltage_choice, torque_const_high_double, torque_const_low_half, speed_input_kind,
    closed_loop_inhibit;
  wire [11:0] accel_current_limit_ma, lock_current_threshold_ma, sense_current_threshold_ma;
  wire [9:0] dead_time_ns;
  int bad_count = 0;
  int num_checks = 0;
  logic [7:0] d;
  logic ok;
  logic [7:0] wv [6] = '{8'h7f, 8'ha5, 8'h5f, 8'ha9, 8'h1e, 8'hdb};
  logic [7:0] ev [6] = '{8'h7f, 8'ha5, 8'h5e, 8'ha9, 8'h1e, 8'hdb};
  always #5 clock = ~clock;
  host_model i_host_model(.clock, .reg_rdata, .reg_rvalid, .reg_addr, .reg_write, .reg_read, .reg_wdata);
  motor_control_option_registers i_motor_control_option_registers(.clock, .rstn, .reg_addr, .reg_write,
    .reg_read, .reg_wdata, .reg_rdata, .reg_rvalid, .handover_valid, .handover_speed_mhz, .rotor_align_duration,
    .no_motor_fault_enable, .lock_enable_torque_const, .lock_enable_abnormal_speed, .lock_enable_current,
    .inductive_surge_guard_enable, .mechanical_surge_guard_enable, .mechanical_surge_guard_target,
    .sense_release_style, .accel_limit_enable, .accel_current_limit_ma, .lock_current_threshold_ma,
    .lock_enable_closed_stuck, .closed_loop_ramp, .dead_time_ns, .dead_time_below_min_12v,
    .dead_time_below_min_24v, .sense_enable, .sense_current_threshold_ma, .lock_enable_open_stuck,
    .buck_voltage_choice, .sense_pulse_rate, .tach_open_loop_choice, .tach_choice_reserved,
    .tach_pulse_ratio, .torque_const_high_double, .torque_const_low_half, .speed_input_kind,
    .closed_loop_inhibit);
  task automatic chk(input string n, input logic [17:0] e, input logic [17:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #200000;
    bad_count++;
    final_report;
  end
  initial
  begin
    repeat (8) @(negedge clock);
    rstn = 1'b1;
    repeat (2) @(negedge clock);
    chk("dead", 16'h0028, dead_time_ns);
    chk("lock", 16'h0190, lock_current_threshold_ma);
    chk("dead min", 18'h0_0003, {dead_time_below_min_12v, dead_time_below_min_24v});
    for (int i = 0; i < 6; i++)
    begin
      i_host_model.rd(8'h26 + i[7:0], d, ok);
      chk("reset", 16'h0001, {d, ok});
      i_host_model.wr(8'h26 + i[7:0], wv[i]);
      i_host_model.rd(8'h26 + i[7:0], d, ok);
      chk("readback", {ev[i], 8'h01}, {d, 7'h00, ok});
    end
    chk("speed", 16'h2ee0, handover_speed_mhz);
    chk("accel", 16'h03e8, accel_current_limit_ma);
    chk("lock", 16'h0c80, lock_current_threshold_ma);
    chk("dead", 16'h0190, dead_time_ns);
    chk("sense", 16'h0190, sense_current_threshold_ma);
    chk("reserved", 16'h0001, tach_choice_reserved);
    chk("align", 18'h0_000f, {handover_valid, rotor_align_duration});
    chk("lock bits", 18'h0_00a5, {no_motor_fault_enable, lock_enable_torque_const, lock_enable_abnormal_speed,
      lock_enable_current, inductive_surge_guard_enable, mechanical_surge_guard_enable,
      mechanical_surge_guard_target, sense_release_style});
    chk("accel on", 18'h0_0001, accel_limit_enable);
    chk("gate bits", 18'h0_0028, {lock_enable_closed_stuck, closed_loop_ramp, dead_time_below_min_12v,
      dead_time_below_min_24v});
    chk("sense bits", 18'h0_001e, {sense_enable, lock_enable_open_stuck, buck_voltage_choice,
      sense_pulse_rate});
    chk("tach bits", 18'h0_00db, {tach_open_loop_choice, tach_pulse_ratio, torque_const_low_half,
      torque_const_high_double, speed_input_kind, closed_loop_inhibit});
    i_host_model.wr(8'h26, 8'h80);
    i_host_model.wr(8'h2c, 8'hff);
    chk("speed", 16'h3200, handover_speed_mhz);
    i_host_model.wr(8'h26, 8'hff);
    i_host_model.wr(8'h29, 8'h08);
    chk("speed", 18'h3_2000, handover_speed_mhz);
    i_host_model.wr(8'h26, 8'h00);
    i_host_model.rd(8'h2c, d, ok);
    chk("valid", 16'h0000, handover_valid);
    chk("dead", 18'h0_0168, dead_time_ns);
    chk("dead min", 18'h0_0001, {dead_time_below_min_12v, dead_time_below_min_24v});
    chk("unmapped", 16'h0001, {d, ok});
    i_host_model.rd(8'h25, d, ok);
    chk("unmapped", 16'h0001, {d, ok});
    final_report;
  end
endmodule
bind motor_control_option_registers motor_option_monitor i_motor_option_monitor(.clock, .rstn, .reg_addr,
  .reg_write, .reg_read, .reg_wdata, .reg_rdata, .reg_rvalid, .handover_speed_mhz, .no_motor_fault_enable,
  .accel_current_limit_ma, .dead_time_ns, .closed_loop_inhibit);
`default_nettype wire

// >>> verif/motor_option_monitor.sv
// Purpose: port checker for the motor option register bank
// Assumes: single clock, synchronous active-low reset
// Notes: decoded outputs trail a write by two edges
`timescale 1ns/1ps
`default_nettype none
module motor_option_monitor
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // decoded settings
  input wire logic [17:0] handover_speed_mhz,
  input wire logic no_motor_fault_enable,
  input wire logic [11:0] accel_current_limit_ma,
  input wire logic [9:0] dead_time_ns,
  input wire logic closed_loop_inhibit
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  read_answer_a: assert property (reg_read |=> reg_rvalid) else $error("read not answered");
  answer_cause_a: assert property (reg_rvalid |-> $past(reg_read)) else $error("stray read answer");
  unmapped_zero_a: assert property (reg_read && (reg_addr < 8'h26 || reg_addr > 8'h2b) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  handover_speed_a: assert property (reg_write && reg_addr == 8'h26 |-> ##2 handover_speed_mhz ==
    ($past(reg_wdata[7], 2) ? ($past(reg_wdata[6:3], 2) + 32'd1) * 12800 : $past(reg_wdata[7:3], 2) * 800))
    else $error("handover speed wrong");
  no_motor_a: assert property (reg_write && reg_addr == 8'h27 |-> ##2 no_motor_fault_enable == $past(reg_wdata[7], 2))
    else $error("no motor enable wrong");
  accel_limit_a: assert property (reg_write && reg_addr == 8'h28 |-> ##2
    accel_current_limit_ma == $past(reg_wdata[7:4], 2) * 12'd200) else $error("accel limit wrong");
  dead_time_a: assert property (reg_write && reg_addr == 8'h29 |-> ##2
    dead_time_ns == ($past(reg_wdata[3:0], 2) + 10'd1) * 10'd40) else $error("dead time wrong");
  loop_inhibit_a: assert property (reg_write && reg_addr == 8'h2b |-> ##2 closed_loop_inhibit == $past(reg_wdata[0], 2))
    else $error("inhibit wrong");
endmodule
`default_nettype wire
